// file: dv/tb_top.sv
// self-checking testbench for the output bank and divider block
`timescale 1ns/1ps
module tb_top;
  import obd_pkg::*;

  logic         clock, rst, cfg_load, x_edge, y_edge;
  logic [2:0]   x_cnt, y_cnt;
  logic [3:0]   x_skew, y_skew;
  logic [159:0] div_m1, dv;
  logic [3:0]   own_x, own_y;
  logic         clipped;
  logic [7:0]   sym_cl, out_clk, prv;
  logic [8:0]   e;
  integer       seed = 32'hf3b3599e;
  int           fails = 0;
  int           n_checks = 0;
  int           hi[8], ri[8], rat[8];
  int           k, s, per, hgh, x, y, w;
  logic         drv;
  int           tx[5] = '{4, 0, 2, 1, 4};
  int           ty[5] = '{0, 4, 1, 3, 0};
  logic         tex[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic         tey[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  int           cx[4] = '{3, 5, 0, 2};
  int           cy[4] = '{2, 0, 7, 2};

  obd_bank_ctrl uut (
    .CLOCK(clock), .RST(rst), .CFG_LOAD(cfg_load),
    .X_BANK_COUNT(x_cnt), .Y_BANK_COUNT(y_cnt),
    .X_SKEW(x_skew), .Y_SKEW(y_skew), .DIV_M1(div_m1),
    .X_EDGE(x_edge), .Y_EDGE(y_edge),
    .BANK_X_OWN(own_x), .BANK_Y_OWN(own_y), .Y_CLIPPED(clipped),
    .SYM_CLAMPED(sym_cl), .OUT_CLK(out_clk)
  );

  // 40 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // expected clip flag, Y owners and X owners
  function automatic logic [8:0] own_fn(input int x, input int y);
    int         xc, yc;
    logic [3:0] xo, yo;
    xc = (x > 4) ? 4 : x;
    yc = (y > 4 - xc) ? 4 - xc : y;
    xo = 4'((1 << xc) - 1);
    yo = 4'((1 << (xc + yc)) - 1) & ~xo;
    return {(x > 4) || (x + y > 4), yo, xo};
  endfunction : own_fn

  // expected period and high time in clocks, one edge per clock
  function automatic void per_fn(input int p, input int n,
                                 output int per, output int hgh);
    if (SYM_PORT_MASK[p])
    begin
      per = (n == 1) ? 4 : 2 * n;
      hgh = per / 2;
    end
    else
    begin
      per = 2 * n;
      hgh = (n == 1) ? 1 : 2 * ((n + 1) / 2);
    end
  endfunction : per_fn

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic do_reset();
    @(negedge clock);
    rst = 1'b1;
    repeat (16) @(negedge clock);
    rst = 1'b0;
  endtask : do_reset

  // one configuration load with owner and clamp checks
  task automatic load(input int x, input int y, input logic [3:0] xs,
                      input logic [3:0] ys, input logic [159:0] d);
    logic [7:0] es;
    for (int p = 0; p < 8; p++)
      es[p] = SYM_PORT_MASK[p] && (d[p*20 +: 20] == 20'h00000);
    e = own_fn(x, y);
    @(negedge clock);
    {cfg_load, x_cnt, y_cnt, x_skew, y_skew, div_m1} =
      {1'b1, 3'(x), 3'(y), xs, ys, d};
    @(negedge clock);
    cfg_load = 1'b0;
    @(negedge clock);
    chk(own_x, e[3:0]);
    chk(own_y, e[7:4]);
    chk(clipped, e[8]);
    @(negedge clock);
    chk(sym_cl, es);
  endtask : load

  // main sequence
  initial
  begin
    {rst, cfg_load, x_edge, y_edge, x_cnt, y_cnt} = '0;
    {x_skew, y_skew, div_m1} = '0;
    do_reset();
    // ownership, clipping and clamp, corners first then random
    for (int i = 0; i < 30; i++)
    begin
      x = (i < 4) ? cx[i] : ({$random(seed)} % 8);
      y = (i < 4) ? cy[i] : ({$random(seed)} % 8);
      for (int p = 0; p < 8; p++)
        dv[p*20 +: 20] = ($random(seed) & 1) ? 20'h0 : 20'($random(seed));
      if (i == 4)
        dv = {8{20'hFFFFF}};
      load(x, y, 4'($random(seed)), 4'($random(seed)), dv);
    end
    // skew latency from a single rising edge on port 1
    for (int i = 0; i < 6; i++)
    begin
      s = (i == 1) ? 15 : (i == 2) ? 3 : (i < 4) ? 0 : {$random(seed)} % 16;
      do_reset();
      load((i % 2) ? 0 : 4, (i % 2) ? 4 : 0, 4'(s), 4'(s), '0);
      @(negedge clock);
      x_edge = (i % 2 == 0);
      y_edge = (i % 2 == 1);
      @(negedge clock);
      {x_edge, y_edge} = 2'b00;
      k = 1;
      while (out_clk[0] !== 1'b1 && k < 40)
      begin
        @(negedge clock);
        k++;
      end
      if (k >= 40)
      begin
        fails++;
        final_report();
      end
      else
        chk(k, s + 1);
    end
    // divider duty and period under each ownership pattern
    for (int t = 0; t < 5; t++)
    begin
      do_reset();
      w = (t == 4) ? 220 : 240;
      for (int p = 0; p < 8; p++)
      begin
        // last pass: odd ratio above nine on every port
        rat[p] = (t == 4) ? 11 : 1 + {$random(seed)} % 6;
        dv[p*20 +: 20] = 20'(rat[p] - 1);
      end
      load(tx[t], ty[t], 4'($random(seed)), 4'($random(seed)), dv);
      x_edge = tex[t];
      y_edge = tey[t];
      repeat (100) @(negedge clock);
      prv = out_clk;
      hi = '{default: 0};
      ri = '{default: 0};
      repeat (w)
      begin
        @(negedge clock);
        for (int p = 0; p < 8; p++)
        begin
          hi[p] += out_clk[p];
          ri[p] += out_clk[p] & ~prv[p];
        end
        prv = out_clk;
      end
      {x_edge, y_edge} = 2'b00;
      for (int p = 0; p < 8; p++)
      begin
        per_fn(p, rat[p], per, hgh);
        drv = (e[p/2] && tex[t]) || (e[4 + p/2] && tey[t]);
        chk(hi[p], drv ? w / per * hgh : 0);
        chk(ri[p], drv ? w / per : 0);
      end
    end
    final_report();
  end

endmodule : tb_top

// file: hdl/obd_bank_ctrl.sv
// module: output bank ownership, skew delay and port dividers
`timescale 1ns/1ps
module obd_bank_ctrl
  import obd_pkg::*;
(
  input  wire logic                              CLOCK,
  input  wire logic                              RST,
  input  wire logic                              CFG_LOAD,
  input  wire logic [obd_pkg::BANK_CNT_W-1:0]    X_BANK_COUNT,
  input  wire logic [obd_pkg::BANK_CNT_W-1:0]    Y_BANK_COUNT,
  input  wire logic [obd_pkg::SKEW_W-1:0]        X_SKEW,
  input  wire logic [obd_pkg::SKEW_W-1:0]        Y_SKEW,
  input  wire logic [obd_pkg::NUM_PORTS*obd_pkg::DIV_W-1:0] DIV_M1,
  input  wire logic                              X_EDGE,
  input  wire logic                              Y_EDGE,
  output logic      [obd_pkg::NUM_BANKS-1:0]     BANK_X_OWN,
  output logic      [obd_pkg::NUM_BANKS-1:0]     BANK_Y_OWN,
  output logic                                   Y_CLIPPED,
  output logic      [obd_pkg::NUM_PORTS-1:0]     SYM_CLAMPED,
  output logic      [obd_pkg::NUM_PORTS-1:0]     OUT_CLK
);
  import obd_pkg::*;

  //--------------------------------------------------------------------------
  // configuration registers, loaded together on CFG_LOAD
  //--------------------------------------------------------------------------
  logic [NUM_BANKS-1:0]       x_own_ff;
  logic [NUM_BANKS-1:0]       y_own_ff;
  logic                       clip_ff;
  logic [SKEW_W-1:0]          skew_ff [NUM_SIDES];
  logic [NUM_PORTS*DIV_W-1:0] div_m1_ff;
  logic [NUM_BANKS-1:0]       nxt_x_own;
  logic [NUM_BANKS-1:0]       nxt_y_own;
  logic [BANK_CNT_W-1:0]      x_eff;
  logic [BANK_CNT_W-1:0]      y_lim;
  logic [BANK_CNT_W-1:0]      y_eff;
  logic [BANK_CNT_W-1:0]      xy_end;
  logic                       nxt_clip;

  // X clipped to all banks, Y to what X leaves
  assign x_eff    = (X_BANK_COUNT > BANK_CNT_MAX) ? BANK_CNT_MAX : X_BANK_COUNT;
  assign y_lim    = BANK_CNT_W'(BANK_CNT_MAX - x_eff);
  assign y_eff    = (Y_BANK_COUNT > y_lim) ? y_lim : Y_BANK_COUNT;
  assign xy_end   = BANK_CNT_W'(x_eff + y_eff);
  assign nxt_clip = (X_BANK_COUNT > BANK_CNT_MAX) || (Y_BANK_COUNT > y_lim);

  // X from the first bank upward, Y right after X's last bank
  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++)
    begin : g_own
      assign nxt_x_own[b] = (BANK_CNT_W'(b) < x_eff);
      assign nxt_y_own[b] = (BANK_CNT_W'(b) >= x_eff) &&
                            (BANK_CNT_W'(b) < xy_end);
    end
  endgenerate

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      x_own_ff        <= '0;
      y_own_ff        <= '0;
      clip_ff         <= 1'b0;
      skew_ff[SIDE_X] <= SKEW_RST;
      skew_ff[SIDE_Y] <= SKEW_RST;
      div_m1_ff       <= {NUM_PORTS{DIV_M1_RST}};
    end
    else if (CFG_LOAD)
    begin
      x_own_ff        <= nxt_x_own;
      y_own_ff        <= nxt_y_own;
      clip_ff         <= nxt_clip;
      skew_ff[SIDE_X] <= X_SKEW;
      skew_ff[SIDE_Y] <= Y_SKEW;
      div_m1_ff       <= DIV_M1;
    end
  end

  assign BANK_X_OWN = x_own_ff;
  assign BANK_Y_OWN = y_own_ff;
  assign Y_CLIPPED  = clip_ff;

  //--------------------------------------------------------------------------
  // per-side skew delay line and edge phase
  //--------------------------------------------------------------------------
  logic [NUM_SIDES-1:0] tick;
  logic [NUM_SIDES-1:0] rise;
  logic [NUM_SIDES-1:0] ph_ff;

  genvar s;
  generate
    for (s = 0; s < NUM_SIDES; s++)
    begin : g_side
      logic [SKEW_MAX:1] dly_ff;
      wire               edge_in;

      assign edge_in = (s == SIDE_X) ? X_EDGE : Y_EDGE;
      // zero skew taps the undelayed edge
      assign tick[s] = (skew_ff[s] == '0) ? edge_in : dly_ff[skew_ff[s]];
      assign rise[s] = ~ph_ff[s];   // first edge after reset is rising

      always_ff @(posedge CLOCK)
      begin
        if (RST)
        begin
          dly_ff   <= '0;
          ph_ff[s] <= 1'b0;
        end
        else
        begin
          dly_ff   <= {dly_ff[SKEW_MAX-1:1], edge_in};
          ph_ff[s] <= ph_ff[s] ^ tick[s];
        end
      end
    end
  endgenerate

  //--------------------------------------------------------------------------
  // port dividers, port p sits in bank p/2
  //--------------------------------------------------------------------------
  logic [NUM_PORTS-1:0] port_en;
  logic [NUM_PORTS-1:0] port_x;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      localparam int BANK = p / PORTS_PER_BNK;

      // both ports of a bank read the same owner bits
      assign port_x[p]  = x_own_ff[BANK];
      assign port_en[p] = x_own_ff[BANK] | y_own_ff[BANK];

      obd_port_div #(
        .SYMMETRIC (SYM_PORT_MASK[p]),
        .WIDTH     (DIV_W)
      ) u_div (
        .clk      (CLOCK),
        .rst      (RST),
        .en       (port_en[p]),
        .edge_en  (port_x[p] ? tick[SIDE_X] : tick[SIDE_Y]),
        .src_rise (port_x[p] ? rise[SIDE_X] : rise[SIDE_Y]),
        .ratio_m1 (div_m1_ff[p*DIV_W +: DIV_W]),
        .clk_out  (OUT_CLK[p]),
        .clamped  (SYM_CLAMPED[p])
      );
    end
  endgenerate

  //--------------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------------
  // banks in use by either side, requested bank total
  logic [NUM_BANKS-1:0]  used;
  logic [BANK_CNT_W:0]   cnt_sum;
  assign used    = x_own_ff | y_own_ff;
  assign cnt_sum = {1'b0, X_BANK_COUNT} + {1'b0, Y_BANK_COUNT};

  // an X edge followed by three cycles at skew three
  sequence s_edge_skew3;
    (X_EDGE && skew_ff[SIDE_X] == 4'h3) ##1 (skew_ff[SIDE_X] == 4'h3) [*3];
  endsequence

  // loads that hand every bank to one side
  sequence s_load_x_all;
    CFG_LOAD && (X_BANK_COUNT >= BANK_CNT_MAX);
  endsequence

  sequence s_load_y_all;
    CFG_LOAD && (X_BANK_COUNT == '0) && (Y_BANK_COUNT >= BANK_CNT_MAX);
  endsequence

  // no bank is driven by both sides
  a_bank_exclusive: assert property (
    @(posedge CLOCK) disable iff (RST) (x_own_ff & y_own_ff) == '0)
    else $error("bank owned by both sides");

  // X banks form one run from the first bank
  a_x_from_first: assert property (
    @(posedge CLOCK) disable iff (RST)
    ((x_own_ff + 1'b1) & x_own_ff) == '0)
    else $error("X banks not contiguous from the first");

  // all used banks form one run, no gap after X
  a_banks_contig: assert property (
    @(posedge CLOCK) disable iff (RST) ((used + 1'b1) & used) == '0)
    else $error("Y banks leave a gap after X");

  // Y starts on the bank right after the last X bank
  a_y_after_x: assert property (
    @(posedge CLOCK) disable iff (RST)
    (y_own_ff != '0) |-> ((y_own_ff & (x_own_ff + 1'b1)) != '0))
    else $error("Y banks do not start right after X");

  // unowned banks keep both of their ports low
  a_pair_together: assert property (
    @(posedge CLOCK) disable iff (RST) (OUT_CLK & ~$past(port_en)) == '0)
    else $error("port of an unowned bank still toggles");

  // owners and clip flag hold between loads
  a_own_hold: assert property (
    @(posedge CLOCK) disable iff (RST)
    !CFG_LOAD |=> ($stable(x_own_ff) && $stable(y_own_ff) &&
                   $stable(clip_ff)))
    else $error("bank owners changed without a load");

  // a full X count leaves nothing for Y
  a_x_full_wins: assert property (
    @(posedge CLOCK) disable iff (RST)
    s_load_x_all |=> (x_own_ff == 4'hF) && (y_own_ff == 4'h0))
    else $error("X at full count did not own every bank");

  // Y alone may feed every bank while X is idle
  a_y_full_alone: assert property (
    @(posedge CLOCK) disable iff (RST)
    s_load_y_all |=> (y_own_ff == 4'hF) && (x_own_ff == 4'h0))
    else $error("Y alone did not own every bank");

  // fitting counts raise no clip, excess fills every bank
  a_clip_clear: assert property (
    @(posedge CLOCK) disable iff (RST)
    (CFG_LOAD && cnt_sum <= BANK_CNT_MAX) |=> !Y_CLIPPED)
    else $error("clip flag raised for counts that fit");

  a_clip_full: assert property (
    @(posedge CLOCK) disable iff (RST)
    (CFG_LOAD && cnt_sum > BANK_CNT_MAX) |=> (Y_CLIPPED && used == 4'hF))
    else $error("excess counts did not fill every bank");

  // zero skew uses the Y edge in the same cycle
  a_skew_zero: assert property (
    @(posedge CLOCK) disable iff (RST)
    (skew_ff[SIDE_Y] == '0 && Y_EDGE)
      |=> (ph_ff[SIDE_Y] != $past(ph_ff[SIDE_Y])))
    else $error("zero skew still delays the edge");

  // an X edge at skew three is used three cycles later
  a_skew_three: assert property (
    @(posedge CLOCK) disable iff (RST) s_edge_skew3 |-> tick[SIDE_X])
    else $error("skew of three did not delay by three cycles");

endmodule : obd_bank_ctrl

// file: hdl/obd_pkg.sv
// package: constants and summary of operation of the output bank block
// Summary of operation
// - Output ports one to eight form four banks of two consecutive ports.
// - A bank's source applies to both of its ports together, never apart.
// - Banks hold ports 1-2, 3-4, 5-6 and 7-8, first to fourth in order.
// - Either PLL side may drive any bank, so one side alone can feed all.
// - Each side claims banks contiguously; Y follows X and is clipped to the banks X leaves.
// - Each side's reference-to-VCXO skew is programmable down to zero.
// - Ports 2, 4, 5 and 7 alone correct duty cycle for every odd ratio from 3 up.
// - Symmetry-corrected ports offer no bypass and divide by at least 2.
// - Ports 1, 3, 6 and 8 may bypass the divider or use any 20-bit ratio.
// - Every port divider accepts any ratio up to 1,048,576; corrected ports run 1 as 2.
package obd_pkg;

  //--------------------------------------------------------------------------
  // structure
  //--------------------------------------------------------------------------
  localparam int          NUM_PORTS     = 8;
  localparam int          NUM_BANKS     = 4;
  localparam int          PORTS_PER_BNK = 2;
  localparam int          NUM_SIDES     = 2;
  localparam int          SIDE_X        = 0;
  localparam int          SIDE_Y        = 1;
  localparam int          BANK_CNT_W    = 3;
  localparam logic [2:0]  BANK_CNT_MAX  = 3'h4;

  //--------------------------------------------------------------------------
  // dividers: field holds ratio minus one, so 0 means divide by 1
  //--------------------------------------------------------------------------
  localparam int          DIV_W         = 20;
  localparam int          DIV_MAX_RATIO = 1048576;
  localparam logic [7:0]  SYM_PORT_MASK = 8'h5A; // ports 2,4,5,7

  //--------------------------------------------------------------------------
  // skew delay and reset values
  //--------------------------------------------------------------------------
  localparam int          SKEW_W        = 4;
  localparam int          SKEW_MAX      = 15;
  localparam logic [2:0]  BANK_CNT_RST  = 3'h0;
  localparam logic [3:0]  SKEW_RST      = 4'h0;
  localparam logic [19:0] DIV_M1_RST    = 20'h00000;
  localparam int          CLK_HZ        = 40000000;

endpackage : obd_pkg

// file: hdl/obd_port_div.sv
// module: one output port divider driven by source edge enables
`timescale 1ns/1ps
module obd_port_div
  import obd_pkg::*;
#(
  parameter bit SYMMETRIC = 1'b0,
  parameter int WIDTH     = 20
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             en,
  input  wire logic             edge_en,
  input  wire logic             src_rise,
  input  wire logic [WIDTH-1:0] ratio_m1,
  output logic                  clk_out,
  output logic                  clamped
);

  //--------------------------------------------------------------------------
  // ratio decode
  //--------------------------------------------------------------------------
  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;
  logic             out_ff;
  logic             nxt_out;
  logic             clamp_ff;
  wire              ratio_one;
  wire              bypass;
  wire [WIDTH-1:0]  eff_m1;
  wire              count_tick;
  wire              at_end;

  assign ratio_one  = (ratio_m1 == '0);
  // corrected ports never bypass, ratio 1 runs as 2
  assign eff_m1     = (SYMMETRIC && ratio_one) ? WIDTH'(1) : ratio_m1;
  assign bypass     = !SYMMETRIC && ratio_one;
  // corrected ports count both edges for 50/50 odd ratios
  assign count_tick = edge_en && (SYMMETRIC || src_rise);
  assign at_end     = (cnt_ff == eff_m1);

  //--------------------------------------------------------------------------
  // next count and output level
  //--------------------------------------------------------------------------
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    if (!en)
    begin
      nxt_cnt = '0;
      nxt_out = 1'b0;
    end
    else if (bypass)
    begin
      if (edge_en)
        nxt_out = src_rise;   // follows source
    end
    else if (count_tick)
    begin
      nxt_cnt = at_end ? '0 : cnt_ff + 1'b1;   // full 20-bit range
      if (SYMMETRIC)
      begin
        if (at_end)
          nxt_out = ~out_ff;  // toggle every n edges
      end
      else
        nxt_out = (nxt_cnt <= (eff_m1 >> 1));  // high ceil(n/2) of n
    end
  end

  //--------------------------------------------------------------------------
  // state
  //--------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_ff   <= '0;
      out_ff   <= 1'b0;
      clamp_ff <= 1'b0;
    end
    else
    begin
      cnt_ff   <= nxt_cnt;
      out_ff   <= nxt_out;
      clamp_ff <= SYMMETRIC && ratio_one;
    end
  end

  assign clk_out = out_ff;
  assign clamped = clamp_ff;

  //--------------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------------
  a_sym_no_bypass: assert property (@(posedge clk) disable iff (rst)
    (SYMMETRIC && en && ratio_one && edge_en && cnt_ff == '0)
      |=> $stable(out_ff))
    else $error("corrected port passed an edge straight through");

  a_bypass_follow: assert property (@(posedge clk) disable iff (rst)
    (!SYMMETRIC && en && ratio_one && edge_en)
      |=> (out_ff == $past(src_rise)))
    else $error("bypass port did not follow its source");

  a_sym_toggle: assert property (@(posedge clk) disable iff (rst)
    (SYMMETRIC && en && edge_en && at_end) |=> (out_ff != $past(out_ff)))
    else $error("corrected port missed its half-period toggle");

  a_period_wrap: assert property (@(posedge clk) disable iff (rst)
    (en && !bypass && count_tick && at_end) |=> (cnt_ff == '0))
    else $error("divider count did not wrap at its ratio");

endmodule : obd_port_div
